// ### rtl/host_port_pkg.sv
// constants and types shared by the dual channel host bus port
package host_port_pkg;

    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_TIME_NS = 45000;
    // longest allowed time, so the division rounds down
    localparam int WAKE_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 16;

    // ==================================================================
    // register map (standard uart layout, one bank of eight per channel)
    localparam logic [2:0] MODEM_CTRL_OFFSET = 3'h4;
    localparam int IRQ_OUT_EN_BIT = 3;
    localparam int REG_COUNT = 16;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] IRQ_OUT_EN_RESET = 2'h0;

    // ==================================================================
    // power behaviour
    // partial sleep stops the oscillator and keeps the charge pump
    localparam logic PARTIAL_STOPS_OSC = 1'b1;

    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_PARTIAL,
        PM_FULL,
        PM_SAVE
    } pwr_mode_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_RD_WAIT,
        PH_RD_DRIVE,
        PH_WR_HOLD
    } bus_phase_t;

    // ==================================================================
    // bus pins as seen after synchronisation
    typedef struct packed {
        logic style;
        logic cs_a_n;
        logic cs_b_n;
        logic rd_n;
        logic wr_n;
        logic [2:0] addr;
        logic [7:0] data;
        logic [1:0] hw_mode;
    } pin_t;

    localparam pin_t PIN_RESET = '{style: 1'b1, cs_a_n: 1'b1,
        cs_b_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0,
        data: 8'h00, hw_mode: 2'h0};

endpackage : host_port_pkg

// ### rtl/host_reg_mem.sv
// register bank of both channels with a registered read port
`timescale 1ns/1ps
module host_reg_mem (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // write port
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read port, data one cycle after the address
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data
);
    import host_port_pkg::*;

    typedef struct packed {
        logic [REG_COUNT-1:0][7:0] cells;
        logic [7:0] rd_data;
    } mem_state_t;

    mem_state_t st;
    mem_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.rd_data = st.cells[rd_addr];
        if (wr_en) begin
            next_st.cells[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '{cells: {REG_COUNT{REG_RESET}}, rd_data: REG_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;

endmodule : host_reg_mem

// ### rtl/dual_uart_host_bus_port.sv
// host bus port of a two channel uart: decode, interrupts, power modes
// ======================================================================
// Overview of operation
// R1: three address lines pick the register
// R2: eight bit data bus, both directions
// R3: read strobe fall drives addressed byte out
// R4: write strobe rise stores the data byte
// R5: style low: ignore read strobe, write is r/w
// R6: style high: separate selects for channels a, b
// R7: style low: channel a select selects the device
// R8: style low: channel b select picks the channel
// R9: strobe style: irq a high, enabled by control bit
// R10: strobe style: irq b high, enabled by control bit
// R11: r/w style: irq a shared, low, open drain
// R12: r/w style: irq b unused
// R13: four power modes, active after reset
// R14: partial stops one source, full stops both
// R15: power save isolates the bus pins
// R16: wake interrupt on leaving low power
// R17: wake completes within the wake time
// R18: standard uart register layout per channel
// R19: no select means no access, bus undriven
`timescale 1ns/1ps
module dual_uart_host_bus_port #(
    parameter int unsigned WAKE_CYCLES = host_port_pkg::WAKE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host bus pins
    input wire logic bus_style,
    input wire logic [2:0] addr,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // interrupt pins and core requests
    input wire logic chan_a_irq_req,
    input wire logic chan_b_irq_req,
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe,
    // power control
    input wire logic [1:0] hw_mode_pin,
    input wire logic [1:0] sw_mode_req,
    output logic osc_en,
    output logic pump_en,
    output logic bus_isolate,
    output logic wake_busy,
    output logic wake_irq
);
    import host_port_pkg::*;

    // ==================================================================
    // state
    typedef struct packed {
        pin_t sync1;
        pin_t sync2;
        bus_phase_t phase;
        logic rd_prev;
        logic wr_prev;
        logic [3:0] lat_addr;
        logic [7:0] lat_data;
        logic [7:0] data_out;
        logic data_oe;
        logic [1:0] irq_out_en;
        logic irq_a_out;
        logic irq_a_oe;
        logic irq_b_out;
        logic irq_b_oe;
        pwr_mode_t mode;
        logic waking;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic wake_irq;
        logic osc_en;
        logic pump_en;
        logic isolate;
    } port_state_t;

    localparam port_state_t STATE_RESET = '{sync1: PIN_RESET,
        sync2: PIN_RESET, phase: PH_IDLE, rd_prev: 1'b0, wr_prev: 1'b0,
        lat_addr: 4'h0, lat_data: 8'h00, data_out: 8'h00, data_oe: 1'b0,
        irq_out_en: IRQ_OUT_EN_RESET, irq_a_out: 1'b0, irq_a_oe: 1'b0,
        irq_b_out: 1'b0, irq_b_oe: 1'b0, mode: PM_ACTIVE, waking: 1'b0,
        wake_cnt: '0, wake_irq: 1'b0, osc_en: 1'b1, pump_en: 1'b1,
        isolate: 1'b0};

    port_state_t st;
    port_state_t next_st;
    pin_t pin_now;
    pin_t p;

    logic sel_any;
    logic bus_chan;
    logic bus_live;
    logic rd_act;
    logic wr_act;
    logic rd_go;
    logic wr_go;
    logic mem_we;
    logic [3:0] mem_rd_addr;
    logic [7:0] mem_rd_data;
    pwr_mode_t req_mode;

    // ==================================================================
    // bus decode on synchronised pins
    assign pin_now = '{style: bus_style, cs_a_n: chan_a_select_n,
        cs_b_n: chan_b_select_n, rd_n: read_strobe_n,
        wr_n: write_strobe_n, addr: addr, data: data_in,
        hw_mode: hw_mode_pin};
    assign p = st.sync2;

    // strobe style: both selects live; r/w style: only channel a select
    assign sel_any = p.style ? (!p.cs_a_n || !p.cs_b_n)
                             : !p.cs_a_n; // [R6] [R7]
    // a wins when both selects are low in strobe style
    assign bus_chan = p.style ? p.cs_a_n : p.cs_b_n; // [R8]
    assign bus_live = sel_any && !st.isolate; // [R15] [R19]
    assign rd_act = bus_live && (p.style ? !p.rd_n : p.wr_n); // [R3] [R5]
    assign wr_act = bus_live && !p.wr_n; // [R4] [R5]
    assign rd_go = rd_act && !st.rd_prev && (st.phase == PH_IDLE);
    assign wr_go = wr_act && !st.wr_prev && (st.phase == PH_IDLE);
    assign mem_rd_addr = {bus_chan, p.addr}; // [R1] [R18]
    assign mem_we = (st.phase == PH_WR_HOLD) && !wr_act; // [R4]

    assign req_mode = (p.hw_mode != 2'h0) ? pwr_mode_t'(p.hw_mode)
                                          : pwr_mode_t'(sw_mode_req);

    host_reg_mem u_regs (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(mem_we),
        .wr_addr(st.lat_addr),
        .wr_data(st.lat_data),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // ==================================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.sync1 = pin_now;
        next_st.sync2 = st.sync1;
        next_st.rd_prev = rd_act;
        next_st.wr_prev = wr_act;
        next_st.wake_irq = 1'b0;

        unique case (st.phase)
            PH_IDLE: begin
                if (rd_go) begin
                    next_st.lat_addr = mem_rd_addr; // [R3]
                    next_st.phase = PH_RD_WAIT;
                end else if (wr_go) begin
                    next_st.lat_addr = mem_rd_addr;
                    next_st.lat_data = p.data;
                    next_st.phase = PH_WR_HOLD;
                end
            end
            PH_RD_WAIT: begin
                next_st.data_out = mem_rd_data; // [R2] [R3]
                next_st.data_oe = rd_act;
                next_st.phase = rd_act ? PH_RD_DRIVE : PH_IDLE;
            end
            PH_RD_DRIVE: begin
                if (!rd_act) begin
                    next_st.data_oe = 1'b0; // [R19]
                    next_st.phase = PH_IDLE;
                end
            end
            PH_WR_HOLD: begin
                // data keeps following the pins until the strobe ends
                if (wr_act) begin
                    next_st.lat_data = p.data; // [R2]
                end else begin
                    next_st.phase = PH_IDLE;
                    if (st.lat_addr[2:0] == MODEM_CTRL_OFFSET) begin
                        next_st.irq_out_en[st.lat_addr[3]] =
                            st.lat_data[IRQ_OUT_EN_BIT]; // [R4] [R9]
                    end
                end
            end
        endcase

        // interrupt pins
        if (p.style) begin
            next_st.irq_a_out = chan_a_irq_req; // [R9]
            next_st.irq_a_oe = st.irq_out_en[0]; // [R9]
            next_st.irq_b_out = chan_b_irq_req; // [R10]
            next_st.irq_b_oe = st.irq_out_en[1]; // [R10]
        end else begin
            // open drain: only ever pulls low
            next_st.irq_a_out = 1'b0; // [R11]
            next_st.irq_a_oe = chan_a_irq_req || chan_b_irq_req; // [R11]
            next_st.irq_b_out = 1'b0; // [R12]
            next_st.irq_b_oe = 1'b0; // [R12]
        end

        // power modes
        if (st.waking) begin
            next_st.wake_cnt = st.wake_cnt - 1'b1;
            if (st.wake_cnt == 16'h0001) begin
                next_st.waking = 1'b0; // [R17]
            end
        end
        if (req_mode != st.mode) begin
            next_st.mode = req_mode; // [R13]
            if (req_mode == PM_ACTIVE) begin
                next_st.waking = 1'b1;
                next_st.wake_cnt = WAKE_CNT_W'(WAKE_CYCLES); // [R17]
                next_st.wake_irq = 1'b1; // [R16]
            end else begin
                next_st.waking = 1'b0;
            end
        end
        next_st.osc_en = !((next_st.mode == PM_FULL) ||
            (next_st.mode == PM_SAVE) ||
            ((next_st.mode == PM_PARTIAL) && PARTIAL_STOPS_OSC)); // [R14]
        next_st.pump_en = !((next_st.mode == PM_FULL) ||
            (next_st.mode == PM_SAVE) ||
            ((next_st.mode == PM_PARTIAL) && !PARTIAL_STOPS_OSC)); // [R14]
        next_st.isolate = (next_st.mode == PM_SAVE); // [R15]
        if (next_st.isolate) begin
            next_st.data_oe = 1'b0; // [R15]
        end
    end

    // async reset loads only the constant; mode starts active
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= STATE_RESET; // [R13]
        end else begin
            st <= next_st;
        end
    end

    // ==================================================================
    // outputs
    assign data_out = st.data_out;
    assign data_oe = st.data_oe;
    assign chan_a_irq_out = st.irq_a_out;
    assign chan_a_irq_oe = st.irq_a_oe;
    assign chan_b_irq_out = st.irq_b_out;
    assign chan_b_irq_oe = st.irq_b_oe;
    assign osc_en = st.osc_en;
    assign pump_en = st.pump_en;
    assign bus_isolate = st.isolate;
    assign wake_busy = st.waking;
    assign wake_irq = st.wake_irq;

    // ==================================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_READ_DRIVES: assert property ( // [R3]
        rd_go ##1 rd_act |=> data_oe)
        else $error("read strobe did not drive the bus");

    AST_READ_DATA: assert property ( // [R1] [R2]
        rd_go ##1 1'b1 |=> data_out == $past(mem_rd_data))
        else $error("read byte differs from addressed register");

    AST_CTRL_WRITE: assert property ( // [R4]
        mem_we && st.lat_addr == {1'b0, MODEM_CTRL_OFFSET}
        |=> st.irq_out_en[0] == $past(st.lat_data[IRQ_OUT_EN_BIT]))
        else $error("control write did not reach the enable bit");

    AST_NO_SELECT: assert property ( // [R19]
        (!sel_any)[*3] |-> !data_oe)
        else $error("bus driven without a chip select");

    AST_RW_STYLE_READ: assert property ( // [R5] [R7]
        !p.style && !p.cs_a_n && p.wr_n && !st.isolate |-> rd_act)
        else $error("r/w line read not decoded");

    AST_CHAN_SELECT: assert property ( // [R8]
        rd_go && !p.style |=> st.lat_addr[3] == $past(p.cs_b_n))
        else $error("channel line not used as address");

    AST_IRQ_STROBE: assert property ( // [R9] [R10]
        p.style |=> chan_a_irq_oe == $past(st.irq_out_en[0]) &&
            chan_b_irq_oe == $past(st.irq_out_en[1]) &&
            chan_a_irq_out == $past(chan_a_irq_req))
        else $error("interrupt pins wrong in strobe style");

    AST_IRQ_SHARED: assert property ( // [R11] [R12]
        !p.style |=> !chan_a_irq_out && !chan_b_irq_oe &&
            chan_a_irq_oe == $past(chan_a_irq_req || chan_b_irq_req))
        else $error("shared interrupt wrong in r/w style");

    AST_FULL_SLEEP: assert property ( // [R14]
        st.mode == PM_FULL |-> !osc_en && !pump_en)
        else $error("full sleep left a source running");

    AST_ISOLATE: assert property ( // [R15]
        bus_isolate |-> !rd_act && !wr_act && !data_oe)
        else $error("bus reached the core while isolated");

    AST_WAKE_IRQ: assert property ( // [R16]
        st.mode != PM_ACTIVE && req_mode == PM_ACTIVE |=> wake_irq)
        else $error("no wake interrupt on leaving sleep");

    AST_WAKE_END: assert property ( // [R17]
        wake_busy && st.wake_cnt == 16'h0001 |=> !wake_busy)
        else $error("wake did not finish on time");

    CVR_STROBE_READ: cover property (p.style && rd_go ##2 data_oe);
    CVR_RW_WRITE: cover property (!p.style && mem_we);
    CVR_WAKE: cover property ($fell(wake_busy));
    CVR_SAVE: cover property (bus_isolate);

endmodule : dual_uart_host_bus_port

// ### testbench/host_bus_model.sv
// host processor model that drives the parallel bus pins
`timescale 1ns/1ps
module host_bus_model (
    // clock and style
    input wire logic ref_clk,
    input wire logic bus_style,
    // bus pins
    output logic [2:0] addr,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic chan_a_select_n,
    output logic chan_b_select_n,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    initial begin
        addr = 3'h0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chan_a_select_n = 1'b1;
        chan_b_select_n = 1'b1;
        data_in = 8'h00;
    end

    // ==================================================================
    // one bus cycle; sel low leaves both selects idle in strobe style, only the channel a select in r/w style
    task automatic access(input logic wr, input logic ch, input logic sel,
        input logic [2:0] a, input logic [7:0] wd,
        output logic [7:0] rd, output logic seen);
        seen = 1'b0;
        rd = 8'h00;
        @(negedge ref_clk);
        addr = a;
        data_in = wr ? wd : ~data_in;
        // r/w style: read strobe opposes the access, so it must be ignored
        read_strobe_n = bus_style ? wr : ~wr;
        write_strobe_n = ~wr;
        if (bus_style) begin
            chan_a_select_n = ~(sel & ~ch);
            chan_b_select_n = ~(sel & ch);
        end else begin
            chan_a_select_n = ~sel;
            chan_b_select_n = ch;
        end
        repeat (10) begin
            @(negedge ref_clk);
            if (data_oe === 1'b1 && !seen) begin
                seen = 1'b1;
                rd = data_out;
            end
        end
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chan_a_select_n = 1'b1;
        chan_b_select_n = 1'b1;
        // data held past the release: the device samples it late
        repeat (3) @(negedge ref_clk);
        data_in = ~data_in;
        repeat (3) @(negedge ref_clk);
    endtask : access
endmodule : host_bus_model

// ### testbench/dual_uart_host_bus_port_tb_top.sv
// self-checking bench of the dual channel host bus port
`timescale 1ns/1ps
module dual_uart_host_bus_port_tb_top;
    import host_port_pkg::*;
    localparam int WAKE = 8;
    logic ref_clk, rst, bus_style, irq_a, irq_b, data_oe, seen;
    logic read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n;
    logic a_out, a_oe, b_out, b_oe, osc_en, pump_en, bus_isolate;
    logic wake_busy, wake_irq;
    logic [1:0] hw_mode, sw_mode;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, rd;
    int error_cnt, total_checks, cnt;

    dual_uart_host_bus_port #(.WAKE_CYCLES(WAKE)) i_dual_uart_host_bus_port (
        .ref_clk(ref_clk), .rst(rst), .bus_style(bus_style), .addr(addr),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chan_a_select_n(chan_a_select_n),
        .chan_b_select_n(chan_b_select_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .chan_a_irq_req(irq_a),
        .chan_b_irq_req(irq_b), .chan_a_irq_out(a_out),
        .chan_a_irq_oe(a_oe), .chan_b_irq_out(b_out), .chan_b_irq_oe(b_oe),
        .hw_mode_pin(hw_mode), .sw_mode_req(sw_mode), .osc_en(osc_en),
        .pump_en(pump_en), .bus_isolate(bus_isolate),
        .wake_busy(wake_busy), .wake_irq(wake_irq));

    host_bus_model i_host_bus_model (
        .ref_clk(ref_clk), .bus_style(bus_style), .addr(addr),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chan_a_select_n(chan_a_select_n),
        .chan_b_select_n(chan_b_select_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==================================================================
    // helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic ch, input logic [2:0] a,
        input logic [7:0] d);
        i_host_bus_model.access(1'b1, ch, 1'b1, a, d, rd, seen);
    endtask : wr

    // sel low means the read must be refused
    task automatic rd_chk(input logic ch, input logic [2:0] a,
        input logic [7:0] exp, input logic sel);
        i_host_bus_model.access(1'b0, ch, sel, a, 8'h00, rd, seen);
        check(seen, sel);
        if (sel) check(rd, exp);
        check(data_oe, 8'h00);
    endtask : rd_chk

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_n

    // ==================================================================
    // scenarios
    task automatic t_reset();
        check({osc_en, pump_en, bus_isolate}, 8'h06);
        check({wake_busy, wake_irq, data_oe}, 8'h00);
        check({a_oe, b_oe}, 8'h00);
    endtask : t_reset

    task automatic t_strobe();
        wr(1'b0, 3'h1, 8'h5a);
        wr(1'b1, 3'h1, 8'ha5);
        wr(1'b0, 3'h7, 8'h3c);
        rd_chk(1'b0, 3'h1, 8'h5a, 1'b1);
        rd_chk(1'b1, 3'h1, 8'ha5, 1'b1);
        rd_chk(1'b0, 3'h7, 8'h3c, 1'b1);
        rd_chk(1'b1, 3'h4, 8'h00, 1'b1);
        i_host_bus_model.access(1'b1, 1'b0, 1'b0, 3'h1, 8'hff, rd, seen);
        rd_chk(1'b0, 3'h1, 8'h5a, 1'b1);
        rd_chk(1'b0, 3'h1, 8'h00, 1'b0);
    endtask : t_strobe

    task automatic t_irq_strobe();
        irq_a = 1'b1;
        irq_b = 1'b1;
        wait_n(5);
        check({a_oe, b_oe}, 8'h00);
        wr(1'b0, 3'h4, 8'h08);
        wr(1'b1, 3'h4, 8'h08);
        check({a_out, a_oe, b_out, b_oe}, 8'h0f);
        irq_a = 1'b0;
        wait_n(5);
        check({a_out, a_oe, b_out, b_oe}, 8'h07);
        wr(1'b0, 3'h4, 8'h00);
        wr(1'b1, 3'h4, 8'h00);
        check({a_oe, b_oe}, 8'h00);
    endtask : t_irq_strobe

    task automatic t_rw_style();
        bus_style = 1'b0;
        irq_b = 1'b0;
        wait_n(6);
        wr(1'b1, 3'h2, 8'hc3);
        rd_chk(1'b1, 3'h2, 8'hc3, 1'b1);
        rd_chk(1'b0, 3'h2, 8'h00, 1'b1);
        rd_chk(1'b0, 3'h1, 8'h5a, 1'b0);
        irq_b = 1'b1;
        wait_n(5);
        check({a_out, a_oe, b_oe}, 8'h02);
        irq_b = 1'b0;
        wait_n(5);
        check({a_oe, b_oe}, 8'h00);
        bus_style = 1'b1;
        wait_n(6);
    endtask : t_rw_style

    task automatic t_power();
        sw_mode = 2'h1;
        wait_n(2);
        check({osc_en, pump_en}, 8'h01);
        sw_mode = 2'h2;
        wait_n(2);
        check({osc_en, pump_en, bus_isolate}, 8'h00);
        sw_mode = 2'h3;
        wait_n(2);
        check(bus_isolate, 8'h01);
        rd_chk(1'b0, 3'h1, 8'h5a, 1'b0);
        // selected accesses must not reach the core while isolated
        i_host_bus_model.access(1'b1, 1'b0, 1'b1, 3'h1, 8'h11, rd, seen);
        i_host_bus_model.access(1'b0, 1'b0, 1'b1, 3'h1, 8'h00, rd, seen);
        check(seen, 8'h00);
        sw_mode = 2'h0;
        wait_n(1);
        check({osc_en, pump_en, wake_irq, wake_busy}, 8'h0f);
        wait_n(1);
        check(wake_irq, 8'h00);
        cnt = 1;
        while (wake_busy === 1'b1 && cnt < 50) begin
            cnt++;
            wait_n(1);
        end
        check(cnt <= WAKE, 8'h01);
        rd_chk(1'b0, 3'h1, 8'h5a, 1'b1);
        hw_mode = 2'h2;
        wait_n(5);
        check({osc_en, pump_en}, 8'h00);
        hw_mode = 2'h0;
        wait_n(WAKE + 6);
        check({osc_en, pump_en, bus_isolate, wake_busy}, 8'h0c);
    endtask : t_power

    // ==================================================================
    // verdict and run control
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        // whole run is a few hundred cycles
        #100000;
        error_cnt++;
        final_report();
    end

    initial begin
        error_cnt = 0;
        total_checks = 0;
        rst = 1'b1;
        bus_style = 1'b1;
        irq_a = 1'b0;
        irq_b = 1'b0;
        hw_mode = 2'h0;
        sw_mode = 2'h0;
        wait_n(12);
        rst = 1'b0;
        wait_n(4);
        t_reset();
        t_strobe();
        t_irq_strobe();
        t_rw_style();
        t_power();
        final_report();
    end
endmodule : dual_uart_host_bus_port_tb_top
